/* File: rtl/aux_compare_unit.sv */
`timescale 1ns/1ns
`default_nettype none

module aux_compare_unit (
	input wire logic [15:0] lhs,
	input wire logic [15:0] rhs,
	input wire logic [1:0] mode,
	output var logic result
);

	// both operands are unsigned
	always_comb begin
		unique case (mode)
			2'h0: result = (lhs == rhs);
			2'h1: result = (lhs < rhs);
			2'h2: result = (lhs > rhs);
			2'h3: result = (lhs != rhs);
		endcase
	end

endmodule

`default_nettype wire

/* File: rtl/hw_call_stack.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ram_cfg_defines.svh"

module hw_call_stack (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic push,
	input wire logic [15:0] pushValue,
	output logic [15:0] stackTop
);

	logic [15:0] level_reg [`STACK_DEPTH];
	logic [15:0] level_next [`STACK_DEPTH];

	// a push shifts every level down; the deepest entry falls off
	always_comb begin
		level_next[0] = push ? pushValue : level_reg[0];
	end

	genvar i;
	generate
		for (i = 1; i < `STACK_DEPTH; i++) begin : g_level
			always_comb begin
				level_next[i] = push ? level_reg[i-1] : level_reg[i];
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int k = 0; k < `STACK_DEPTH; k++) begin
				level_reg[k] <= 16'h0000;
			end
		end else begin
			for (int k = 0; k < `STACK_DEPTH; k++) begin
				level_reg[k] <= level_next[k];
			end
		end
	end

	assign stackTop = level_reg[0];

	a_push_shift: assert property (@(posedge ref_clk) disable iff (!rst_n)
		push |=> level_reg[1] == $past(level_reg[0]))
		else $error("stack did not shift down on push");

endmodule

`default_nettype wire

/* File: rtl/ram_cfg_defines.svh */
`ifndef RAM_CFG_DEFINES_SVH
`define RAM_CFG_DEFINES_SVH

// opcodes of the handled instructions
`define OPC_RAM_TO_DATA 16'hCE04
`define OPC_RAM_TO_PROG 16'hCE05
`define OPC_CALL_ACC 16'hCE24
`define OPC_ACC_INVERT 16'hCE27
`define OPC_MAP_BASE 16'hCE3C
`define OPC_COMPARE_BASE 16'hCE50
`define OPC_FIELD_MASK 16'hFFFC

// register offsets (byte addresses)
`define REG_STATUS 8'h00
`define REG_ACC_LO 8'h04
`define REG_PC 8'h08
`define REG_STACK_TOP 8'h0C
`define REG_ACC_HI 8'h10
`define REG_AUX_BASE 8'h20

// status word field positions
`define STAT_CFG_BIT 0
`define STAT_MAP_LO 1
`define STAT_MAP_HI 2
`define STAT_TEST_FLAG 3
`define STAT_AUX_PTR_LSB 4
`define STAT_AUX_PTR_MSB 6
`define STAT_BLOCKS_LSB 8
`define STAT_BLOCKS_MSB 11

// program-space block patterns, bit i set = block i in program space
`define BLOCKS_MAP_00 4'h0
`define BLOCKS_MAP_01 4'h1
`define BLOCKS_MAP_10 4'h3
`define BLOCKS_MAP_11 4'hB

// reset values and counts
`define PC_RESET 16'h0000
`define STACK_DEPTH 8
`define FETCH_HOLD 2'h2
`define CALL_CYCLES 2

`endif

/* File: rtl/ram_cfg_pkg.sv */
package ram_cfg_pkg;

	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_EXEC, ST_SETTLE} exec_state_t;

	typedef enum logic [2:0] {
		OP_NONE, OP_DATA_MAP, OP_PROG_MAP, OP_MAP_SEL, OP_COMPARE, OP_INVERT, OP_CALL_ACC
	} exec_op_t;

endpackage

/* File: rtl/ram_config_and_aux_compare_exec.sv */
// How it works
// - map instruction copies field into map-select bits
// - data-space map clears the RAM-config bit
// - unsigned aux compare against aux zero sets flag
// - one cycle (two for the accumulator call), plus waits, n when repeated
// - accumulator call pushes PC+1, loads ACC low
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "ram_cfg_defines.svh"

module ram_config_and_aux_compare_exec
	import ram_cfg_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic instrValid,
	input wire logic [15:0] instrWord,
	input wire logic fromExternal,
	input wire logic [3:0] waitStates,
	input wire logic [7:0] repeatCount,
	input wire logic [7:0] busAddr,
	input wire logic [31:0] busWrData,
	input wire logic busWr,
	input wire logic busRd,
	output logic [31:0] busRdData,
	output logic instrReady,
	output logic instrDone,
	output logic ramBlockConfigBit,
	output logic ramMapSelectLow,
	output logic ramMapSelectHigh,
	output logic [3:0] programBlocks,
	output logic fetchRamConfig,
	output logic testControlFlag
);

	function automatic exec_op_t decodeOp(input logic [15:0] word);
		if (word == `OPC_RAM_TO_DATA) return OP_DATA_MAP;
		if (word == `OPC_RAM_TO_PROG) return OP_PROG_MAP;
		if (word == `OPC_CALL_ACC) return OP_CALL_ACC;
		if (word == `OPC_ACC_INVERT) return OP_INVERT;
		if ((word & `OPC_FIELD_MASK) == `OPC_MAP_BASE) return OP_MAP_SEL;
		if ((word & `OPC_FIELD_MASK) == `OPC_COMPARE_BASE) return OP_COMPARE;
		return OP_NONE;
	endfunction

	function automatic logic [3:0] blockMap(input logic [1:0] sel);
		unique case (sel)
			2'h0: return `BLOCKS_MAP_00;
			2'h1: return `BLOCKS_MAP_01;
			2'h2: return `BLOCKS_MAP_10;
			2'h3: return `BLOCKS_MAP_11;
		endcase
	endfunction

	function automatic logic isAuxAddr(input logic [7:0] addr);
		return addr[7:5] == 3'(`REG_AUX_BASE >> 5) && addr[1:0] == 2'h0;
	endfunction

	// control group
	exec_state_t state_reg, state_next;
	exec_op_t op_reg, op_next;
	logic [1:0] field_reg, field_next;
	logic [3:0] waitCnt_reg, waitCnt_next;
	logic [7:0] repCnt_reg, repCnt_next;
	logic ready_reg, ready_next;
	logic done_reg, done_next;

	// architectural group
	logic cfgBit_reg, cfgBit_next;
	logic [1:0] mapSel_reg, mapSel_next;
	logic [3:0] blocks_reg, blocks_next;
	logic testFlag_reg, testFlag_next;
	logic [2:0] auxPointer_reg, auxPointer_next;
	logic [15:0] aux_reg [8];
	logic [15:0] aux_next [8];
	logic [31:0] acc_reg, acc_next;
	logic [15:0] pc_reg, pc_next;
	logic fetchCfg_reg, fetchCfg_next;
	logic pendCfg_reg, pendCfg_next;
	logic [1:0] hold_reg, hold_next;

	// bus group
	logic [31:0] rdData_reg, rdData_next;

	logic accept;
	logic execNow;
	logic lastExec;
	logic compareTrue;
	logic [15:0] stackTop;
	logic push;

	assign accept = instrValid && ready_reg;
	assign execNow = state_reg == ST_EXEC;
	assign lastExec = execNow && repCnt_reg == 8'h01;
	assign push = execNow && op_reg == OP_CALL_ACC;

	aux_compare_unit u_compare (
		.lhs(aux_reg[auxPointer_reg]),
		.rhs(aux_reg[0]),
		.mode(field_reg),
		.result(compareTrue)
	);

	hw_call_stack u_stack (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.push(push),
		.pushValue(pc_reg + 16'h0001),
		.stackTop(stackTop)
	);

	always_comb begin
		state_next = state_reg;
		op_next = op_reg;
		field_next = field_reg;
		waitCnt_next = waitCnt_reg;
		repCnt_next = repCnt_reg;
		ready_next = ready_reg;
		done_next = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				if (accept) begin
					op_next = decodeOp(instrWord);
					field_next = instrWord[1:0];
					// the call cannot repeat; zero count means a single pass
					if (decodeOp(instrWord) == OP_CALL_ACC || repeatCount == 8'h00) begin
						repCnt_next = 8'h01;
					end else begin
						repCnt_next = repeatCount;
					end
					waitCnt_next = fromExternal ? waitStates : 4'h0;
					ready_next = 1'b0;
					state_next = (fromExternal && waitStates != 4'h0) ? ST_WAIT : ST_EXEC;
				end
			end
			ST_WAIT: begin
				waitCnt_next = waitCnt_reg - 4'h1;
				if (waitCnt_reg == 4'h1) begin
					state_next = ST_EXEC;
				end
			end
			ST_EXEC: begin
				repCnt_next = repCnt_reg - 8'h01;
				if (repCnt_reg == 8'h01) begin
					if (op_reg == OP_CALL_ACC) begin
						state_next = ST_SETTLE;
					end else begin
						state_next = ST_IDLE;
						ready_next = 1'b1;
						done_next = 1'b1;
					end
				end
			end
			ST_SETTLE: begin
				state_next = ST_IDLE;
				ready_next = 1'b1;
				done_next = 1'b1;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			op_reg <= OP_NONE;
			field_reg <= 2'h0;
			waitCnt_reg <= 4'h0;
			repCnt_reg <= 8'h00;
			ready_reg <= 1'b1;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			op_reg <= op_next;
			field_reg <= field_next;
			waitCnt_reg <= waitCnt_next;
			repCnt_reg <= repCnt_next;
			ready_reg <= ready_next;
			done_reg <= done_next;
		end
	end

	// bus writes first, instruction effects override in the same cycle
	always_comb begin
		cfgBit_next = cfgBit_reg;
		mapSel_next = mapSel_reg;
		testFlag_next = testFlag_reg;
		auxPointer_next = auxPointer_reg;
		acc_next = acc_reg;
		pc_next = pc_reg;
		pendCfg_next = pendCfg_reg;
		hold_next = hold_reg;
		fetchCfg_next = fetchCfg_reg;
		for (int k = 0; k < 8; k++) begin
			aux_next[k] = aux_reg[k];
		end
		if (busWr) begin
			if (busAddr == `REG_STATUS) begin
				auxPointer_next = busWrData[`STAT_AUX_PTR_MSB:`STAT_AUX_PTR_LSB];
			end
			if (busAddr == `REG_ACC_LO) begin
				acc_next[15:0] = busWrData[15:0];
			end
			if (busAddr == `REG_ACC_HI) begin
				acc_next[31:16] = busWrData[15:0];
			end
			if (busAddr == `REG_PC) begin
				pc_next = busWrData[15:0];
			end
			if (isAuxAddr(busAddr)) begin
				aux_next[busAddr[4:2]] = busWrData[15:0];
			end
		end
		// the first two fetches after a config change still see the old value
		if (accept && hold_reg != 2'h0) begin
			hold_next = hold_reg - 2'h1;
			if (hold_reg == 2'h1) begin
				fetchCfg_next = pendCfg_reg;
			end
		end
		if (execNow) begin
			unique case (op_reg)
				OP_DATA_MAP: cfgBit_next = 1'b0;
				OP_PROG_MAP: cfgBit_next = 1'b1;
				OP_MAP_SEL: mapSel_next = field_reg;
				OP_COMPARE: testFlag_next = compareTrue;
				OP_INVERT: acc_next = ~acc_reg;
				OP_CALL_ACC, OP_NONE: begin
				end
			endcase
			if (op_reg == OP_DATA_MAP || op_reg == OP_PROG_MAP) begin
				pendCfg_next = op_reg == OP_PROG_MAP;
				hold_next = `FETCH_HOLD;
			end
		end
		if (lastExec) begin
			pc_next = op_reg == OP_CALL_ACC ? acc_reg[15:0] : pc_reg + 16'h0001;
		end
		blocks_next = blockMap(mapSel_next);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfgBit_reg <= 1'b0;
			mapSel_reg <= 2'h0;
			blocks_reg <= `BLOCKS_MAP_00;
			testFlag_reg <= 1'b0;
			auxPointer_reg <= 3'h0;
			acc_reg <= 32'h0000_0000;
			pc_reg <= `PC_RESET;
			fetchCfg_reg <= 1'b0;
			pendCfg_reg <= 1'b0;
			hold_reg <= 2'h0;
			for (int k = 0; k < 8; k++) begin
				aux_reg[k] <= 16'h0000;
			end
		end else begin
			cfgBit_reg <= cfgBit_next;
			mapSel_reg <= mapSel_next;
			blocks_reg <= blocks_next;
			testFlag_reg <= testFlag_next;
			auxPointer_reg <= auxPointer_next;
			acc_reg <= acc_next;
			pc_reg <= pc_next;
			fetchCfg_reg <= fetchCfg_next;
			pendCfg_reg <= pendCfg_next;
			hold_reg <= hold_next;
			for (int k = 0; k < 8; k++) begin
				aux_reg[k] <= aux_next[k];
			end
		end
	end

	// read data stands only in the cycle after the strobe
	always_comb begin
		rdData_next = 32'h0000_0000;
		if (busRd) begin
			if (busAddr == `REG_STATUS) begin
				rdData_next[`STAT_CFG_BIT] = cfgBit_reg;
				rdData_next[`STAT_MAP_LO] = mapSel_reg[0];
				rdData_next[`STAT_MAP_HI] = mapSel_reg[1];
				rdData_next[`STAT_TEST_FLAG] = testFlag_reg;
				rdData_next[`STAT_AUX_PTR_MSB:`STAT_AUX_PTR_LSB] = auxPointer_reg;
				rdData_next[`STAT_BLOCKS_MSB:`STAT_BLOCKS_LSB] = blocks_reg;
			end
			if (busAddr == `REG_ACC_LO) begin
				rdData_next[15:0] = acc_reg[15:0];
			end
			if (busAddr == `REG_ACC_HI) begin
				rdData_next[15:0] = acc_reg[31:16];
			end
			if (busAddr == `REG_PC) begin
				rdData_next[15:0] = pc_reg;
			end
			if (busAddr == `REG_STACK_TOP) begin
				rdData_next[15:0] = stackTop;
			end
			if (isAuxAddr(busAddr)) begin
				rdData_next[15:0] = aux_reg[busAddr[4:2]];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData_reg <= 32'h0000_0000;
		end else begin
			rdData_reg <= rdData_next;
		end
	end

	assign busRdData = rdData_reg;
	assign instrReady = ready_reg;
	assign instrDone = done_reg;
	assign ramBlockConfigBit = cfgBit_reg;
	assign ramMapSelectLow = mapSel_reg[0];
	assign ramMapSelectHigh = mapSel_reg[1];
	assign programBlocks = blocks_reg;
	assign fetchRamConfig = fetchCfg_reg;
	assign testControlFlag = testFlag_reg;

	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_quick_single;
		accept && !fromExternal && repeatCount <= 8'h01 && decodeOp(instrWord) != OP_CALL_ACC;
	endsequence

	sequence s_two_waits;
		accept && fromExternal && waitStates == 4'h2 && repeatCount <= 8'h01
			&& decodeOp(instrWord) != OP_CALL_ACC;
	endsequence

	a_map_select_copy: assert property (execNow && op_reg == OP_MAP_SEL |=>
		mapSel_reg == $past(field_reg) && blocks_reg == blockMap($past(field_reg)))
		else $error("map select not copied from field");

	a_block_place: assert property (mapSel_reg == 2'h3 |-> blocks_reg == 4'hB)
		else $error("map value three places wrong blocks");

	a_data_map_clear: assert property (execNow && op_reg == OP_DATA_MAP |=> !cfgBit_reg)
		else $error("data map did not clear config bit");

	a_compare_flag: assert property (execNow && op_reg == OP_COMPARE |=> testFlag_reg ==
		$past(field_reg == 2'h0 ? aux_reg[auxPointer_reg] == aux_reg[0] :
		field_reg == 2'h1 ? aux_reg[auxPointer_reg] < aux_reg[0] :
		field_reg == 2'h2 ? aux_reg[auxPointer_reg] > aux_reg[0] :
		aux_reg[auxPointer_reg] != aux_reg[0]))
		else $error("compare flag wrong");

	a_one_cycle: assert property (s_quick_single |=> !instrReady ##1 instrReady && instrDone)
		else $error("single internal instruction not one cycle");

	a_wait_cycles: assert property (s_two_waits |=> !instrReady [*3] ##1 instrReady)
		else $error("wait states not added");

	a_call_push: assert property (push |=>
		stackTop == $past(pc_reg) + 16'h0001 && pc_reg == $past(acc_reg[15:0]))
		else $error("accumulator call wrong push or target");

	a_prog_map_set: assert property (execNow && op_reg == OP_PROG_MAP |=> cfgBit_reg)
		else $error("program map did not set config bit");

	a_fetch_hold: assert property (hold_reg != 2'h0 && !(accept && hold_reg == 2'h1) |=>
		$stable(fetchCfg_reg))
		else $error("fetch config changed too early");

	a_fetch_apply: assert property (accept && hold_reg == 2'h1 |=>
		fetchCfg_reg == $past(pendCfg_reg))
		else $error("fetch config not applied on second fetch");

endmodule

`default_nettype wire

/* File: test/test_ram_config_and_aux_compare_exec.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ram_cfg_defines.svh"

module test_ram_config_and_aux_compare_exec
	import ram_cfg_pkg::*;
;
	logic ref_clk = 1'h0, rst_n = 1'h0, instrValid = 1'h0, fromExternal = 1'h0;
	logic busWr = 1'h0, busRd = 1'h0;
	logic [15:0] instrWord = 16'h0000;
	logic [3:0] waitStates = 4'h0;
	logic [7:0] repeatCount = 8'h00, busAddr = 8'h00;
	logic [31:0] busWrData = 32'h0, busRdData;
	logic instrReady, instrDone, ramBlockConfigBit, ramMapSelectLow, ramMapSelectHigh;
	logic fetchRamConfig, testControlFlag;
	logic [3:0] programBlocks;
	// reference model of the visible state
	logic [15:0] aux[8] = '{default: 16'h0000};
	logic [15:0] pc = 16'h0000, stk = 16'h0000, a0, a1;
	logic [31:0] acc = 32'h0, r, seed = 32'h00008102, expI[$], expR[$];
	logic [3:0] blk = 4'h0;
	logic [2:0] ptr = 3'h0;
	logic cfg = 1'h0, fcfg = 1'h0, pcfg = 1'h0, tf = 1'h0, hi = 1'h0, lo = 1'h0;
	logic rdPend = 1'h0;
	logic [15:0] seqOps[8] = '{16'hCE05, 16'h0, 16'h0, 16'h0, 16'hCE04, 16'h0, 16'h0, 16'h0};
	int cyc = 0, cnt = 2, failCount = 0, checkCount = 0;

	ram_config_and_aux_compare_exec DUT (.*);

	initial begin
		forever #10 ref_clk = ~ref_clk;
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [31:0] st();
		return {20'h0, blk, 1'h0, ptr, tf, hi, lo, cfg};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		checkCount++;
		if (seen !== want) begin
			failCount++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checkCount, failCount);
		if (failCount == 0 && checkCount > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		busWr <= 1'h1;
		busAddr <= a;
		busWrData <= d;
		@(posedge ref_clk);
		busWr <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		busRd <= 1'h1;
		busAddr <= a;
		expR.push_back(e);
		@(posedge ref_clk);
		busRd <= 1'h0;
	endtask

	task automatic issue(input logic [15:0] op, input logic x, input logic [3:0] p,
		input logic [7:0] n);
		int lat, k;
		logic [15:0] e;
		e = (n < 2) ? 16'h0001 : {8'h00, n};
		@(posedge ref_clk);
		instrValid <= 1'h1;
		instrWord <= op;
		fromExternal <= x;
		waitStates <= p;
		repeatCount <= n;
		k = 0;
		@(posedge ref_clk);
		while (instrReady !== 1'h1 && k < 50) begin
			k++;
			@(posedge ref_clk);
		end
		if (k >= 50) failCount++;
		instrValid <= 1'h0;
		lat = (op == `OPC_CALL_ACC) ? 2 : int'(e);
		if (x) lat += int'(p);
		if (cnt < 2) begin
			cnt++;
			if (cnt == 2) fcfg = pcfg;
		end
		if (op == `OPC_RAM_TO_DATA || op == `OPC_RAM_TO_PROG) begin
			cfg = op[0];
			pcfg = op[0];
			cnt = 0;
		end
		if ((op & `OPC_FIELD_MASK) == `OPC_MAP_BASE) begin
			{hi, lo} = op[1:0];
			blk = op[1] ? (op[0] ? 4'hB : 4'h3) : {3'h0, op[0]};
		end
		if ((op & `OPC_FIELD_MASK) == `OPC_COMPARE_BASE) begin
			case (op[1:0])
				2'h0: tf = aux[ptr] == aux[0];
				2'h1: tf = aux[ptr] < aux[0];
				2'h2: tf = aux[ptr] > aux[0];
				default: tf = aux[ptr] != aux[0];
			endcase
		end
		if (op == `OPC_ACC_INVERT && e[0]) acc = ~acc;
		pc = pc + 16'h0001;
		if (op == `OPC_CALL_ACC) begin
			stk = pc;
			pc = acc[15:0];
		end
		expI.push_back({16'(cyc + lat + 1), 7'h0, fcfg, blk, hi, lo, cfg, tf});
		k = 0;
		while (instrDone !== 1'h1 && k < 300) begin
			k++;
			@(posedge ref_clk);
		end
		if (k >= 300) failCount++;
	endtask

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		rdPend <= busRd;
		if (rdPend) begin
			chk(busRdData, expR.size() ? expR.pop_front() : 32'hDEADBEEF);
		end
		if (instrDone === 1'h1) begin
			chk({cyc[15:0], 7'h0, fetchRamConfig, programBlocks, ramMapSelectHigh,
				ramMapSelectLow, ramBlockConfigBit, testControlFlag},
				expI.size() ? expI.pop_front() : 32'hDEADBEEF);
			chk({31'h0, instrReady}, 32'h1);
		end
	end

	initial begin
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'h1;
		rd(`REG_STATUS, 32'h0);
		rd(`REG_PC, 32'h0);
		rd(`REG_STACK_TOP, 32'h0);
		wr(8'h40, 32'hFFFF);
		rd(8'h40, 32'h0);
		rd(8'h02, 32'h0);
		$display("test reset and bus done");
		for (int k = 0; k < 8; k++) begin
			r = xs();
			issue(`OPC_MAP_BASE | 16'(k % 4), r[4], r[3:0], {5'h0, r[7:5]});
			rd(`REG_STATUS, st());
		end
		$display("test map select done");
		for (int k = 0; k < 8; k++) begin
			r = xs();
			issue(seqOps[k], r[4], r[3:0], {6'h0, r[6:5]});
			rd(`REG_STATUS, st());
		end
		$display("test config bit done");
		r = xs();
		wr(`REG_STATUS, {r[31:7], 3'h4, r[3:0]});
		ptr = 3'h4;
		rd(`REG_STATUS, st());
		for (int j = 0; j < 16; j++) begin
			r = xs();
			a0 = (j < 4) ? 16'hFFFF : r[15:0];
			a1 = (j < 4) ? 16'h7FFF : (j >= 12) ? a0 : r[31:16];
			wr(`REG_AUX_BASE, {16'h0, a0});
			wr(`REG_AUX_BASE + 8'h10, {r[31:16], a1});
			aux[0] = a0;
			aux[4] = a1;
			rd(`REG_AUX_BASE + 8'h10, {16'h0, a1});
			issue(`OPC_COMPARE_BASE | 16'(j % 4), r[8], r[3:0], {6'h0, r[10:9]});
		end
		$display("test aux compare done");
		r = xs();
		wr(`REG_ACC_LO, {16'h0, r[15:0]});
		wr(`REG_ACC_HI, {16'h0, r[31:16]});
		acc = r;
		for (int j = 0; j < 4; j++) begin
			issue(`OPC_ACC_INVERT, j[0], 4'h2, 8'(j));
			rd(`REG_ACC_LO, {16'h0, acc[15:0]});
			rd(`REG_ACC_HI, {16'h0, acc[31:16]});
		end
		for (int j = 0; j < 2; j++) begin
			issue(`OPC_CALL_ACC, j[0], 4'h2, 8'h05);
			rd(`REG_PC, {16'h0, pc});
			rd(`REG_STACK_TOP, {16'h0, stk});
		end
		$display("test invert and call done");
		repeat (3) @(posedge ref_clk);
		// every noted expectation must have been met by an observed result
		chk(32'(expI.size() + expR.size()), 32'h0);
		summarize();
	end

	initial begin
		#(20 * 30000);
		failCount++;
		summarize();
	end
endmodule
`default_nettype wire
